// file: eroc_top.sv
// Emergency run override controller: arming, frequency/direction override, fault sorting
// Function
// - Selection code 1 is real override, code 2 is rehearsal.
// - Override runs while a terminal assigned function 51 is asserted.
// - Warning output stays high while the override runs.
// - Frequency, direction and run command are replaced; rest follows prior mode.
// - Override frequency setting drives run frequency, default 60.00 Hz.
// - Direction setting: 0 forward, 1 reverse.
// - Counter increments per activation, only in real mode.
// - Real override suppresses minor faults and keeps running.
// - Real override: ground, overcurrent one, overvoltage trip then auto restart.
// - Real override: diagnostic, overcurrent two, safety error trip normally.
// - Auto restart starts only after retry delay elapses.
// - Restart after retry goes through speed search.
// - Override only in speed-control mode, never in torque mode.
// - Rehearsal runs override without counting and trips on every fault.
module eroc_top #(
  parameter int TICK_DIV = eroc_pkg::TICK_CYCLES
) (
  input  wire logic                         clk,            // 40 MHz clock
  input  wire logic                         rst,            // Async reset, high
  input  wire logic [3:0]                   addr,           // Register index
  input  wire logic [31:0]                  wdata,          // Write data
  input  wire logic                         wr,             // Write strobe
  input  wire logic                         rd,             // Read strobe
  output logic      [31:0]                  rdata,          // Read data, cycle after rd
  input  wire logic [eroc_pkg::NUM_TERMS-1:0] term_in,      // Input terminal levels
  input  wire logic                         torque_mode,    // Drive in torque control
  input  wire logic [15:0]                  norm_freq,      // Normal command frequency
  input  wire logic                         norm_dir,       // Normal command direction
  input  wire logic                         norm_run,       // Normal run command
  input  wire logic [eroc_pkg::F_IGN_W-1:0]  fault_ign,     // Suppressible faults
  input  wire logic [eroc_pkg::F_RST_W-1:0]  fault_rst,     // Ground/overcurrent_level_one/overvoltage
  input  wire logic [eroc_pkg::F_TRIP_W-1:0] fault_trip,    // Diagnostic/overcurrent_level_two/safety
  input  wire logic                         search_done,    // Speed search finished
  output logic      [15:0]                  cmd_freq,       // Frequency to speed control
  output logic                              cmd_dir,        // Direction to speed control
  output logic                              cmd_run,        // Run command
  output logic                              trip_out,       // Trip request to fault handler
  output logic                              search_req,     // Start with speed search
  output logic                              warn_out,       // Override warning
  output logic                              irq             // Interrupt level
);
  localparam int NT = eroc_pkg::NUM_TERMS;
  initial begin
    if (TICK_DIV < 2) $error("TICK_DIV too small");
  end

  logic                  tick;
  logic                  retry_done;
  logic [1:0]            sel_reg, sel_next;
  logic [15:0]           freq_reg, freq_next;
  logic                  dir_reg, dir_next;
  logic [15:0]           cnt_reg, cnt_next;
  logic [15:0]           retry_reg, retry_next;
  logic [7:0]            tfunc_reg [NT], tfunc_next [NT];
  logic [eroc_pkg::IRQ_W-1:0] ist_reg, ist_next, ien_reg, ien_next;
  logic [31:0]           rdata_reg, rdata_next;
  eroc_pkg::eroc_state_t st_reg, st_next;
  logic                  real_q, real_next;
  logic                  armed, trig, mode_real, any_ign, any_rst, any_trip;
  logic [eroc_pkg::IRQ_W-1:0] ev;
  logic                  start_t, cancel_t;
  logic                  trip_reg, trip_next;

  eroc_tick #(.DIV(TICK_DIV)) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  eroc_retry_timer u_retry (
    .clk    (clk),
    .rst    (rst),
    .tick   (tick),
    .start  (start_t),
    .cancel (cancel_t),
    .delay  (retry_reg),
    .done   (retry_done)
  );

  function automatic logic [31:0] tfunc_word(input int base);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      if (base + k < NT) w[k*8 +: 8] = tfunc_reg[base + k];
    end
    return w;
  endfunction

  // Arming and trigger
  always_comb begin
    mode_real = (sel_reg == eroc_pkg::SEL_REAL);
    armed = (mode_real || sel_reg == eroc_pkg::SEL_TEST) && !torque_mode;
    trig  = 1'b0;
    for (int i = 0; i < NT; i++) begin
      if (term_in[i] && tfunc_reg[i] == eroc_pkg::TERM_FUNC_OVR) trig = 1'b1;
    end
    any_ign  = |fault_ign;
    any_rst  = |fault_rst;
    any_trip = |fault_trip;
  end

  // Override sequencer
  always_comb begin
    st_next   = st_reg;
    real_next = real_q;
    start_t   = 1'b0;
    cancel_t  = 1'b0;
    trip_next = trip_reg;
    ev        = '0;
    case (st_reg)
      eroc_pkg::ST_IDLE: begin
        trip_next = 1'b0;
        if (armed && trig) begin
          st_next   = eroc_pkg::ST_RUN;
          real_next = mode_real;
          ev[eroc_pkg::IRQ_START] = 1'b1;
        end
      end
      eroc_pkg::ST_RUN, eroc_pkg::ST_SEARCH: begin
        if (!armed || !trig) begin
          st_next = eroc_pkg::ST_IDLE;
          ev[eroc_pkg::IRQ_STOP] = 1'b1;
        end else if (any_trip || (!real_q && (any_rst || any_ign))) begin
          // Hard faults always trip; rehearsal never suppresses
          st_next   = eroc_pkg::ST_TRIP;
          trip_next = 1'b1;
          ev[eroc_pkg::IRQ_TRIP] = 1'b1;
        end else if (any_rst) begin
          st_next   = eroc_pkg::ST_WAIT;
          trip_next = 1'b1;
          start_t   = 1'b1;
          ev[eroc_pkg::IRQ_RETRY] = 1'b1;
        end else if (st_reg == eroc_pkg::ST_SEARCH && search_done) begin
          st_next = eroc_pkg::ST_RUN;
        end
        // Suppressible faults in real mode fall through: keep running
      end
      eroc_pkg::ST_WAIT: begin
        if (!armed || !trig) begin
          cancel_t  = 1'b1;
          // Trip drops with the state, no stale trip while idle
          trip_next = 1'b0;
          st_next   = eroc_pkg::ST_IDLE;
          ev[eroc_pkg::IRQ_STOP] = 1'b1;
        end else if (any_trip) begin
          cancel_t  = 1'b1;
          st_next   = eroc_pkg::ST_TRIP;
          ev[eroc_pkg::IRQ_TRIP] = 1'b1;
        end else if (retry_done) begin
          trip_next = 1'b0;
          st_next   = eroc_pkg::ST_SEARCH;
        end
      end
      eroc_pkg::ST_TRIP: begin
        // Latched until trigger drops, selection disarms or torque mode is entered
        if (!armed || !trig) begin
          st_next   = eroc_pkg::ST_IDLE;
          trip_next = 1'b0;
          ev[eroc_pkg::IRQ_STOP] = 1'b1;
        end
      end
      default: begin
        st_next   = eroc_pkg::ST_IDLE;
        trip_next = 1'b0;
      end
    endcase
  end

  // Register file
  always_comb begin
    sel_next   = sel_reg;
    freq_next  = freq_reg;
    dir_next   = dir_reg;
    retry_next = retry_reg;
    ien_next   = ien_reg;
    for (int i = 0; i < NT; i++) tfunc_next[i] = tfunc_reg[i];
    cnt_next = cnt_reg;
    if (ev[eroc_pkg::IRQ_START] && mode_real && cnt_reg != 16'hFFFF) begin
      cnt_next = cnt_reg + 16'h0001;
    end
    ist_next = ist_reg;
    if (wr && addr == eroc_pkg::A_IRQCLR) ist_next = ist_reg & ~wdata[eroc_pkg::IRQ_W-1:0];
    ist_next = ist_next | ev;  // Set beats clear
    if (wr) begin
      case (addr)
        eroc_pkg::A_SEL: begin
          // Selection frozen while torque control
          if (!torque_mode) sel_next = wdata[1:0];
        end
        eroc_pkg::A_FREQ:  freq_next  = wdata[15:0];
        eroc_pkg::A_DIR:   dir_next   = wdata[0];
        eroc_pkg::A_RETRY: retry_next = wdata[15:0];
        eroc_pkg::A_IRQEN: ien_next   = wdata[eroc_pkg::IRQ_W-1:0];
        default: begin
          for (int j = 0; j < 3; j++) begin
            if (addr == eroc_pkg::A_TFUNC0 + 4'(j)) begin
              for (int k = 0; k < 4; k++) begin
                if (j*4 + k < NT) tfunc_next[j*4 + k] = wdata[k*8 +: 8];
              end
            end
          end
        end
      endcase
    end
    rdata_next = 32'h0000_0000;
    if (rd) begin
      case (addr)
        eroc_pkg::A_SEL:   rdata_next = {30'h0, sel_reg};
        eroc_pkg::A_FREQ:  rdata_next = {16'h0000, freq_reg};
        eroc_pkg::A_DIR:   rdata_next = {31'h0, dir_reg};
        eroc_pkg::A_CNT:   rdata_next = {16'h0000, cnt_reg};
        eroc_pkg::A_RETRY: rdata_next = {16'h0000, retry_reg};
        eroc_pkg::A_STAT:  rdata_next = {24'h0, 1'b0, trip_reg, armed, st_reg};
        eroc_pkg::A_IRQST: rdata_next = {28'h0, ist_reg};
        eroc_pkg::A_IRQEN: rdata_next = {28'h0, ien_reg};
        eroc_pkg::A_TFUNC0: rdata_next = tfunc_word(0);
        eroc_pkg::A_TFUNC0 + 4'h1: rdata_next = tfunc_word(4);
        eroc_pkg::A_TFUNC0 + 4'h2: rdata_next = tfunc_word(8);
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg    <= eroc_pkg::ST_IDLE;
      real_q    <= 1'b0;
      trip_reg  <= 1'b0;
      sel_reg   <= 2'h0;
      freq_reg  <= eroc_pkg::FREQ_DEFAULT;
      dir_reg   <= eroc_pkg::DIR_FWD;
      cnt_reg   <= 16'h0000;
      retry_reg <= eroc_pkg::RETRY_MS_DEFAULT;
      ist_reg   <= '0;
      ien_reg   <= '0;
      rdata_reg <= 32'h0000_0000;
      for (int i = 0; i < NT; i++) tfunc_reg[i] <= 8'h00;
    end else begin
      st_reg    <= st_next;
      real_q    <= real_next;
      trip_reg  <= trip_next;
      sel_reg   <= sel_next;
      freq_reg  <= freq_next;
      dir_reg   <= dir_next;
      cnt_reg   <= cnt_next;
      retry_reg <= retry_next;
      ist_reg   <= ist_next;
      ien_reg   <= ien_next;
      rdata_reg <= rdata_next;
      for (int i = 0; i < NT; i++) tfunc_reg[i] <= tfunc_next[i];
    end
  end

  // Command mux: outside override, normal path passes untouched
  logic ovr;
  always_comb begin
    ovr        = (st_reg != eroc_pkg::ST_IDLE);
    cmd_freq   = ovr ? freq_reg : norm_freq;
    cmd_dir    = ovr ? dir_reg : norm_dir;
    cmd_run    = ovr ? (st_reg == eroc_pkg::ST_RUN || st_reg == eroc_pkg::ST_SEARCH) : norm_run;
    search_req = (st_reg == eroc_pkg::ST_SEARCH);
    warn_out   = ovr;
    trip_out   = trip_reg;
    irq        = |(ist_reg & ien_reg);
    rdata      = rdata_reg;
  end
endmodule

// file: eroc_pkg.sv
// Package of constants and types for the emergency run override controller
package eroc_pkg;
  localparam logic [1:0]  SEL_REAL        = 2'h1;
  localparam logic [1:0]  SEL_TEST        = 2'h2;
  localparam logic [7:0]  TERM_FUNC_OVR   = 8'h33;   // Function code 51
  localparam logic [15:0] FREQ_DEFAULT    = 16'h1770; // 60.00 Hz in 0.01 Hz
  localparam logic        DIR_FWD         = 1'b0;
  localparam logic        DIR_REV         = 1'b1;
  localparam int          NUM_TERMS       = 11;
  localparam int          CLK_HZ          = 40000000;
  localparam int          MS_PER_S        = 1000;
  localparam int          TICK_CYCLES     = CLK_HZ / MS_PER_S; // One ms tick
  localparam logic [15:0] RETRY_MS_DEFAULT = 16'h03E8;
  // Fault vector group widths
  localparam int F_IGN_W   = 13;  // Suppressible fault group width
  localparam int F_RST_W   = 3;   // Ground, overcurrent one, overvoltage
  localparam int F_TRIP_W  = 3;   // Diagnostic, overcurrent two, safety option
  // Register map
  localparam logic [3:0] A_SEL    = 4'h0;
  localparam logic [3:0] A_FREQ   = 4'h1;
  localparam logic [3:0] A_DIR    = 4'h2;
  localparam logic [3:0] A_CNT    = 4'h3;
  localparam logic [3:0] A_RETRY  = 4'h4;
  localparam logic [3:0] A_STAT   = 4'h5;
  localparam logic [3:0] A_IRQST  = 4'h6;
  localparam logic [3:0] A_IRQEN  = 4'h7;
  localparam logic [3:0] A_IRQCLR = 4'h8;
  localparam logic [3:0] A_TFUNC0 = 4'h9;  // Terminal functions packed, index 9..
  localparam int IRQ_W = 4;
  localparam int IRQ_START = 0;
  localparam int IRQ_STOP  = 1;
  localparam int IRQ_RETRY = 2;
  localparam int IRQ_TRIP  = 3;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_RUN    = 5'b00010,
    ST_WAIT   = 5'b00100,
    ST_SEARCH = 5'b01000,
    ST_TRIP   = 5'b10000
  } eroc_state_t;
endpackage

// file: eroc_tick.sv
// Millisecond enable pulse divider
module eroc_tick #(
  parameter int DIV = eroc_pkg::TICK_CYCLES
) (
  input  wire logic clk,   // System clock
  input  wire logic rst,   // Async reset
  output logic      tick   // One-cycle pulse each period
);
  localparam int W = $clog2(DIV);
  initial begin
    if (DIV < 2) $error("DIV too small");
  end
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  always_comb begin
    cnt_next = (cnt_reg == W'(DIV - 1)) ? '0 : cnt_reg + 1'b1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_reg <= '0;
    else cnt_reg <= cnt_next;
  end
  assign tick = (cnt_reg == W'(DIV - 1));
endmodule

// file: eroc_retry_timer.sv
// Retry delay countdown in millisecond ticks
module eroc_retry_timer (
  input  wire logic        clk,     // System clock
  input  wire logic        rst,     // Async reset
  input  wire logic        tick,    // Millisecond enable
  input  wire logic        start,   // Load delay
  input  wire logic        cancel,  // Abort countdown
  input  wire logic [15:0] delay,   // Delay in ms
  output logic             done     // Pulse when delay elapsed
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        act_reg;
  logic        act_next;
  logic        done_next;
  logic        done_reg;
  always_comb begin
    cnt_next  = cnt_reg;
    act_next  = act_reg;
    done_next = 1'b0;
    if (cancel) begin
      act_next = 1'b0;
    end else if (start) begin
      cnt_next = delay;
      act_next = 1'b1;
    end else if (act_reg && tick) begin
      // First tick may land right after start, so one extra tick guarantees the full delay
      if (cnt_reg == 16'h0000) begin
        act_next  = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 16'h0001;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 16'h0000;
      act_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      act_reg  <= act_next;
      done_reg <= done_next;
    end
  end
  assign done = done_reg;
endmodule

// file: eroc_top_properties.sv
// Port-level assertions for the override controller
module eroc_top_properties #(
  parameter int TICK_DIV = eroc_pkg::TICK_CYCLES
) (
  input wire logic                            clk,         // Clock
  input wire logic                            rst,         // Reset
  input wire logic                            wr,          // Write strobe
  input wire logic [eroc_pkg::NUM_TERMS-1:0]  term_in,     // Terminals
  input wire logic                            torque_mode, // Torque mode
  input wire logic [15:0]                     norm_freq,   // Normal freq
  input wire logic                            norm_dir,    // Normal dir
  input wire logic                            norm_run,    // Normal run
  input wire logic [eroc_pkg::F_TRIP_W-1:0]   fault_trip,  // Hard faults
  input wire logic [15:0]                     cmd_freq,    // Freq out
  input wire logic                            cmd_dir,     // Dir out
  input wire logic                            cmd_run,     // Run out
  input wire logic                            trip_out,    // Trip out
  input wire logic                            search_req,  // Search out
  input wire logic                            warn_out     // Warning
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [eroc_pkg::NUM_TERMS-1:0] term_q;
  logic                           wr_q;
  logic                           steady;
  // A write or terminal change last cycle may legally move the state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) {term_q, wr_q} <= '0;
    else {term_q, wr_q} <= {term_in, wr};
  end
  assign steady = (term_in == term_q) && !wr_q && !torque_mode;
  sequence s_wait;
    trip_out && !cmd_run;
  endsequence
  sequence s_restart;
    search_req && cmd_run && !trip_out;
  endsequence
  idle_pass_a: assert property (!warn_out |-> cmd_freq == norm_freq && cmd_dir == norm_dir && cmd_run == norm_run)
    else $error("idle command not passed through");
  torque_off_a: assert property (torque_mode |=> !warn_out)
    else $error("override active in torque mode");
  drop_idle_a: assert property (term_in == '0 |=> !warn_out)
    else $error("override without trigger");
  trip_stop_a: assert property (trip_out |-> warn_out && !cmd_run && !search_req)
    else $error("trip while running");
  warn_hold_a: assert property (warn_out && steady |=> warn_out)
    else $error("warning dropped during override");
  hard_trip_a: assert property (warn_out && steady && !trip_out && fault_trip != '0 |=> trip_out)
    else $error("hard fault did not trip");
  search_run_a: assert property (search_req |-> cmd_run && warn_out && !trip_out)
    else $error("search without run");
  restart_a: assert property (s_wait ##1 (warn_out && !trip_out) |-> s_restart)
    else $error("restart without speed search");
endmodule

bind eroc_top eroc_top_properties #(.TICK_DIV(TICK_DIV)) u_props (
  .clk(clk), .rst(rst), .wr(wr), .term_in(term_in), .torque_mode(torque_mode), .norm_freq(norm_freq),
  .norm_dir(norm_dir), .norm_run(norm_run), .fault_trip(fault_trip), .cmd_freq(cmd_freq), .cmd_dir(cmd_dir),
  .cmd_run(cmd_run), .trip_out(trip_out), .search_req(search_req), .warn_out(warn_out)
);

// file: eroc_drive_model.sv
// Behavioural speed controller answering speed search requests
module eroc_drive_model (
  input  wire logic       clk,         // Clock
  input  wire logic       rst,         // Reset
  input  wire logic       search_req,  // Search request
  input  wire logic [7:0] lag,         // Search length in cycles
  output logic            search_done  // Search finished
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  always_comb cnt_next = search_req ? cnt_reg + 8'h01 : 8'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_reg <= 8'h00;
    else cnt_reg <= cnt_next;
  end
  // Only while asked, so no stale answer reaches a later search
  assign search_done = search_req && (cnt_reg >= lag);
endmodule

// file: eroc_top_tb.sv
// Self-checking testbench for the override controller
module eroc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4;
  localparam int RTRY = 3;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, torque_mode = 1'b0, norm_dir = 1'b0, norm_run = 1'b1;
  logic search_done, cmd_dir, cmd_run, trip_out, search_req, warn_out, irq;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [eroc_pkg::NUM_TERMS-1:0] term_in = '0;
  logic [15:0] norm_freq = 16'h0123, cmd_freq;
  logic [eroc_pkg::F_IGN_W-1:0] fault_ign = '0;
  logic [2:0] fault_rst = 3'h0, fault_trip = 3'h0;
  logic [7:0] lag = 8'h02;
  int fails = 0, tests_run = 0, n;
  always #12.5 clk = ~clk;
  eroc_top #(.TICK_DIV(DIV)) dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .term_in(term_in),
    .torque_mode(torque_mode), .norm_freq(norm_freq), .norm_dir(norm_dir), .norm_run(norm_run),
    .fault_ign(fault_ign), .fault_rst(fault_rst), .fault_trip(fault_trip), .search_done(search_done),
    .cmd_freq(cmd_freq), .cmd_dir(cmd_dir), .cmd_run(cmd_run), .trip_out(trip_out),
    .search_req(search_req), .warn_out(warn_out), .irq(irq)
  );
  eroc_drive_model drive (
    .clk(clk), .rst(rst), .search_req(search_req), .lag(lag), .search_done(search_done)
  );
  task test_done;
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk) addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Bounded wait for the search request to reach a level
  task wsr(input logic v);
    n = 0;
    while (search_req !== v && n < 40) @(posedge clk) #1 n++;
  endtask
  initial begin
    #(25 * 4000);
    fails++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(eroc_pkg::A_FREQ, 32'h1770);
    rchk(eroc_pkg::A_CNT, 32'h0);
    rchk(eroc_pkg::A_RETRY, 32'h3E8);
    rchk(4'hF, 32'h0);
    wreg(eroc_pkg::A_RETRY, 32'(RTRY));
    wreg(eroc_pkg::A_IRQEN, 32'hF);
    wreg(eroc_pkg::A_TFUNC0, 32'h0033_0000);
    wreg(eroc_pkg::A_FREQ, 32'h0BB8);
    wreg(eroc_pkg::A_DIR, 32'h1);
    for (int s = 0; s < 4; s += 3) begin
      wreg(eroc_pkg::A_SEL, 32'(s));
      @(posedge clk) term_in <= 11'h004;
      cyc(3);
      chk(32'(warn_out), 32'h0);
      @(posedge clk) term_in <= 11'h000;
    end
    @(posedge clk) torque_mode <= 1'b1;
    wreg(eroc_pkg::A_SEL, 32'h1);
    rchk(eroc_pkg::A_SEL, 32'h3);
    @(posedge clk) torque_mode <= 1'b0;
    wreg(eroc_pkg::A_SEL, 32'h1);
    @(posedge clk) torque_mode <= 1'b1;
    term_in <= 11'h004;
    cyc(3);
    chk(32'(warn_out), 32'h0);
    @(posedge clk) torque_mode <= 1'b0;
    cyc(2);
    chk(32'({warn_out, cmd_run, cmd_dir}), 32'h7);
    chk(32'(cmd_freq), 32'h0BB8);
    rchk(eroc_pkg::A_CNT, 32'h1);
    rchk(eroc_pkg::A_STAT, 32'h22);
    @(posedge clk) fault_ign <= '1;
    cyc(3);
    chk(32'({trip_out, cmd_run}), 32'h1);
    @(posedge clk) fault_ign <= '0;
    for (int b = 0; b < 3; b++) begin
      @(posedge clk) fault_rst <= 3'(1 << b);
      lag <= 8'(b * 3);
      @(posedge clk) fault_rst <= 3'h0;
      cyc(1);
      chk(32'({trip_out, cmd_run}), 32'h2);
      wsr(1'b1);
      chk(32'(n + 1 >= RTRY * DIV && n + 1 <= RTRY * DIV + DIV + 2), 32'h1);
      chk(32'(search_req), 32'h1);
      wsr(1'b0);
      chk(32'({warn_out, cmd_run, trip_out, search_req}), 32'hC);
    end
    for (int b = 0; b < 3; b++) begin
      @(posedge clk) fault_trip <= 3'(1 << b);
      @(posedge clk) fault_trip <= 3'h0;
      cyc(3);
      chk(32'(trip_out), 32'h1);
      @(posedge clk) term_in <= 11'h000;
      cyc(2);
      chk(32'(cmd_freq), 32'h0123);
      @(posedge clk) term_in <= 11'h004;
      cyc(2);
      chk(32'(warn_out), 32'h1);
    end
    // Trigger dropped while waiting for restart: trip must clear with the state
    @(posedge clk) fault_rst <= 3'h1;
    @(posedge clk) fault_rst <= 3'h0;
    term_in <= 11'h000;
    cyc(1);
    chk(32'({trip_out, warn_out}), 32'h0);
    rchk(eroc_pkg::A_CNT, 32'h4);
    @(posedge clk) term_in <= 11'h000;
    rchk(eroc_pkg::A_IRQST, 32'hF);
    wreg(eroc_pkg::A_IRQEN, 32'h0);
    cyc(0);
    chk(32'(irq), 32'h0);
    wreg(eroc_pkg::A_IRQEN, 32'hF);
    cyc(0);
    chk(32'(irq), 32'h1);
    wreg(eroc_pkg::A_IRQCLR, 32'hF);
    rchk(eroc_pkg::A_IRQST, 32'h0);
    wreg(eroc_pkg::A_SEL, 32'h2);
    wreg(eroc_pkg::A_DIR, 32'h0);
    @(posedge clk) term_in <= 11'h004;
    cyc(2);
    chk(32'({warn_out, cmd_dir}), 32'h2);
    @(posedge clk) fault_ign <= 13'h0001;
    @(posedge clk) fault_ign <= '0;
    cyc(2);
    chk(32'(trip_out), 32'h1);
    @(posedge clk) term_in <= 11'h000;
    rchk(eroc_pkg::A_CNT, 32'h4);
    test_done();
  end
endmodule
